// ==== drc_defs.vh ====
// Constants for the dual counter with byte scan output.
// Assumes inclusion by bare name from the design file.
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// Counter halves and capture width
`define DRC_HALF_W 16
`define DRC_CAP_W 32
`define DRC_BYTE_W 8

// Scan counter states, binary coded
`define DRC_ST_W 3
`define DRC_ST1 3'h1
`define DRC_ST2 3'h2
`define DRC_ST3 3'h3
`define DRC_ST4 3'h4
`define DRC_ST5 3'h5

// Byte loader index range
`define DRC_IDX_W 2
`define DRC_IDX_LAST 2'h3

// Staging buffer shape
`define DRC_FIFO_DEPTH 16
`define DRC_FIFO_AW 4

// Idle levels of the pins after reset
`define DRC_IDLE_LO 1'h0
`define DRC_IDLE_HI 1'h1

`endif

// ==== drc_counter.v ====
// Dual 16-bit up counter with 32-bit capture latch and byte scan mux.
// Assumes every pin is asynchronous to i_mclk and changes slower than
// a few clock periods; the bus driver resolves the three-state pins.
`include "drc_defs.vh"
`default_nettype none

// Three-stage pin synchroniser with agreement filter
module drc_sync3 #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Raw pin
   input wire i_pin,
   // Filtered level and its falling edge
   output reg o_level,
   output reg o_fall
);
   reg s1; // First stage, read only by s2
   reg s2; // Second stage
   reg s3; // Third stage

   // Shift chain; a change counts once s2 and s3 agree
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         o_level <= RST_VAL;
         o_fall <= 1'b0;
      end else begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         o_fall <= 1'b0;
         // Glitch shorter than one period never reaches o_level
         if (s2 == s3) begin
            o_level <= s3;
            o_fall <= o_level & ~s3;
         end
      end
   end
endmodule

// Byte staging FIFO, flops addressed by index
module drc_fifo #(
   parameter W = 8,
   parameter D = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Discard everything held
   input wire i_flush,
   // Fill side
   input wire i_valid,
   output wire o_ready,
   input wire [W-1:0] i_data,
   // Drain side
   output wire o_valid,
   input wire i_ready,
   output wire [W-1:0] o_data
);
   reg [W-1:0] mem [0:D-1]; // Storage
   reg [AW-1:0] wr_ptr; // Next write slot
   reg [AW-1:0] rd_ptr; // Head slot
   reg [AW:0] fill; // Words held
   wire push; // Accepted write
   wire pop; // Accepted read

   // Honest flags from the fill count
   assign o_ready = (fill != D[AW:0]);
   assign o_valid = (fill != {(AW+1){1'b0}});
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;
   assign o_data = mem[rd_ptr];

   // Pointer and count update; flush wins over traffic
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         fill <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         // Both at once leave the count alone
         if (push & ~pop) begin
            fill <= fill + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            fill <= fill - {{AW{1'b0}}, 1'b1};
         end
      end
   end

   // Data store, no reset needed on payload
   always @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_data;
      end
   end
endmodule

// Contract
// [RQ1] Counter advances on each falling count edge
// [RQ2] Host waits ripple time before reading count
// [RQ3] Two count inputs; high on either inhibits
// [RQ4] Upper half advances on its own falling edge
// [RQ5] Reset low clears all counter bits
// [RQ6] Host keeps reset high before valid counts
// [RQ7] Host holds upper count input low during reset
// [RQ8] 32-bit capture latch holds the count
// [RQ9] Host keeps capture low through ripple time
// [RQ10] Host raises capture before next count edge
// [RQ11] Scan counter counts only while enable low
// [RQ12] Scan falling edge steps to next byte
// [RQ13] State 5 disables drivers and holds there
// [RQ14] Scan low puts data outputs in high impedance
// [RQ15] Scan high and enabled drives selected byte
// [RQ16] Host keeps scan phases at least 500ns
// [RQ17] Restart low resets scan and loads latches
// [RQ18] Enable high disables scan counter and outputs
// [RQ19] Host changes enable only while scan low
// [RQ20] Handoff output high, low from state 5
// [RQ21] Handoff feeds next enable; strobes shared
// [RQ22] Next chained device follows after state 5
// [RQ23] States 1-2 lower counter, 3-4 upper
// [RQ24] Restart returns handoff output high
module drc_counter (
   // Clock and reset
   input wire i_mclk,
   input wire i_rst_n,
   // Count pins
   input wire i_count_a,
   input wire i_alt_count_a,
   input wire i_count_b,
   input wire i_cnt_reset_n,
   // Host strobes
   input wire i_scan,
   input wire i_scan_reset_load_n,
   input wire i_enable_n,
   // Three-state byte bus, output side and enable
   output reg [`DRC_BYTE_W-1:0] o_byte_out_lines,
   output reg o_byte_out_oe,
   // Chain handoff to the next device enable
   output reg o_cascade_n
);
   // Filtered pin levels and edges
   wire cnt_a_lvl; // Count A level
   wire alt_a_lvl; // Alt count A level
   wire cnt_b_fall; // Count B falling edge
   wire cnt_rst_lvl; // Counter reset level, low active
   wire scan_lvl; // Scan level
   wire scan_fall; // Scan falling edge
   wire load_lvl; // Restart/capture level, low active
   wire en_lvl; // Enable level, low active

   // Counter state
   reg [`DRC_HALF_W-1:0] cnt_a; // Lower counter
   reg [`DRC_HALF_W-1:0] cnt_b; // Upper counter
   reg a_gate_prev; // Previous combined A input
   wire a_gate; // Combined A input
   reg [`DRC_CAP_W-1:0] cap; // Capture latch
   reg [`DRC_ST_W-1:0] scan_st; // Scan position

   // Byte loader feeding the staging buffer
   reg ld_busy; // Bytes still to push
   reg [`DRC_IDX_W-1:0] ld_idx; // Byte being pushed
   reg [`DRC_BYTE_W-1:0] ld_byte; // Selected byte
   wire fifo_ready; // Buffer can take a byte
   wire fifo_valid; // Buffer head is valid
   wire [`DRC_BYTE_W-1:0] fifo_head; // Head byte
   wire scan_step; // Scan counter advances
   wire fifo_pop; // Head consumed

   // Pin synchronisers; idle levels follow pin pulls
   drc_sync3 #(.RST_VAL(`DRC_IDLE_LO)) u_sync_ca (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_count_a),
      .o_level(cnt_a_lvl), .o_fall());
   drc_sync3 #(.RST_VAL(`DRC_IDLE_LO)) u_sync_aa (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_alt_count_a),
      .o_level(alt_a_lvl), .o_fall());
   drc_sync3 #(.RST_VAL(`DRC_IDLE_LO)) u_sync_cb (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_count_b),
      .o_level(), .o_fall(cnt_b_fall));
   drc_sync3 #(.RST_VAL(`DRC_IDLE_HI)) u_sync_rst (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_cnt_reset_n),
      .o_level(cnt_rst_lvl), .o_fall());
   drc_sync3 #(.RST_VAL(`DRC_IDLE_LO)) u_sync_scan (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_scan),
      .o_level(scan_lvl), .o_fall(scan_fall));
   drc_sync3 #(.RST_VAL(`DRC_IDLE_HI)) u_sync_load (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_scan_reset_load_n),
      .o_level(load_lvl), .o_fall());
   drc_sync3 #(.RST_VAL(`DRC_IDLE_HI)) u_sync_en (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pin(i_enable_n),
      .o_level(en_lvl), .o_fall());

   // A high on either A input keeps this high, so no falling edge
   assign a_gate = cnt_a_lvl | alt_a_lvl; // see [RQ3]

   // Lower and upper counters
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_a <= {`DRC_HALF_W{1'b0}};
         cnt_b <= {`DRC_HALF_W{1'b0}};
         a_gate_prev <= `DRC_IDLE_LO;
      end else begin
         a_gate_prev <= a_gate;
         if (!cnt_rst_lvl) begin
            // Reset level overrides counting; see [RQ5]
            cnt_a <= {`DRC_HALF_W{1'b0}};
            cnt_b <= {`DRC_HALF_W{1'b0}};
         end else begin
            // Falling edge of combined A input; see [RQ1] [RQ3]
            if (a_gate_prev & ~a_gate) begin
               cnt_a <= cnt_a + {{(`DRC_HALF_W-1){1'b0}}, 1'b1};
            end
            // Upper half has its own input; see [RQ4]
            if (cnt_b_fall) begin
               cnt_b <= cnt_b + {{(`DRC_HALF_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Capture latch follows the count while restart is low
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap <= {`DRC_CAP_W{1'b0}};
      end else if (!load_lvl) begin
         // Transparent load; last value before release is kept
         cap <= {cnt_b, cnt_a}; // see [RQ8] [RQ17]
      end
   end

   // Scan steps only when enabled and not parked in state 5
   assign scan_step = scan_fall & ~en_lvl & (scan_st != `DRC_ST5); // see [RQ11] [RQ18]
   // Each step consumes the byte just shown
   assign fifo_pop = scan_step & load_lvl;

   // Scan position counter
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scan_st <= `DRC_ST1;
      end else if (!load_lvl) begin
         // Restart back to least significant byte; see [RQ17]
         scan_st <= `DRC_ST1;
      end else if (scan_step) begin
         // Next more significant byte; see [RQ12]
         scan_st <= scan_st + {{(`DRC_ST_W-1){1'b0}}, 1'b1};
      end else begin
         // State 5 holds until the next restart; see [RQ13]
         scan_st <= scan_st;
      end
   end

   // Byte picked by loader index, low byte first
   always @* begin
      case (ld_idx)
         2'h0: ld_byte = cap[7:0]; // see [RQ23]
         2'h1: ld_byte = cap[15:8];
         2'h2: ld_byte = cap[23:16];
         2'h3: ld_byte = cap[31:24];
         default: ld_byte = {`DRC_BYTE_W{1'b0}};
      endcase
   end

   // Loader pushes the four latched bytes after each restart
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ld_busy <= 1'b0;
         ld_idx <= {`DRC_IDX_W{1'b0}};
      end else if (!load_lvl) begin
         // Latch still moving; start over after release
         ld_busy <= 1'b1;
         ld_idx <= {`DRC_IDX_W{1'b0}};
      end else if (ld_busy & fifo_ready) begin
         // Full buffer stalls the loader here
         ld_idx <= ld_idx + {{(`DRC_IDX_W-1){1'b0}}, 1'b1};
         if (ld_idx == `DRC_IDX_LAST) begin
            ld_busy <= 1'b0;
         end
      end
   end

   // Staging buffer between latch and byte bus
   drc_fifo #(
      .W(`DRC_BYTE_W),
      .D(`DRC_FIFO_DEPTH),
      .AW(`DRC_FIFO_AW)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_flush(~load_lvl),
      .i_valid(ld_busy & load_lvl),
      .o_ready(fifo_ready),
      .i_data(ld_byte),
      .o_valid(fifo_valid),
      .i_ready(fifo_pop),
      .o_data(fifo_head)
   );

   // Registered bus drive and handoff
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_byte_out_lines <= {`DRC_BYTE_W{1'b0}};
         o_byte_out_oe <= 1'b0;
         o_cascade_n <= 1'b1;
      end else begin
         // Head of buffer is the byte for the present state
         o_byte_out_lines <= fifo_valid ? fifo_head : {`DRC_BYTE_W{1'b0}}; // see [RQ15]
         // Drive only with scan high, enabled, below state 5
         o_byte_out_oe <= scan_lvl & ~en_lvl & (scan_st != `DRC_ST5); // see [RQ14] [RQ18] [RQ13]
         // Low from state 5, high again after restart
         o_cascade_n <= (scan_st != `DRC_ST5); // see [RQ20] [RQ24] [RQ22]
      end
   end
endmodule

`default_nettype wire

// ==== drc_counter_monitor.sv ====
// Checker on the scan bus enable and the chain handoff pin.
// Assumes pins change slowly against i_mclk.
`default_nettype none
module drc_mon (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Host strobes
   input wire logic i_scan,
   input wire logic i_scan_reset_load_n,
   input wire logic i_enable_n,
   // Device outputs
   input wire logic o_byte_out_oe,
   input wire logic o_cascade_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Six edges cover the pin filter and the output flop
   hiz_scan_a: assert property (!i_scan [*6] |-> !o_byte_out_oe)
      else $error("bus driven with scan low");
   en_off_a: assert property (i_enable_n [*6] |-> !o_byte_out_oe)
      else $error("bus driven while disabled");
   st5_off_a: assert property (!o_cascade_n |-> !o_byte_out_oe)
      else $error("bus driven in last state");
   casc_hold_a: assert property (!o_cascade_n && i_scan_reset_load_n |=> !o_cascade_n)
      else $error("handoff left low state early");
   casc_ret_a: assert property (!i_scan_reset_load_n [*8] |-> o_cascade_n)
      else $error("handoff not high after restart");
   oe_on_a: assert property ((i_scan && !i_enable_n && o_cascade_n &&
      i_scan_reset_load_n) [*8] |-> o_byte_out_oe)
      else $error("bus not driven");
   oe_cause_a: assert property ($rose(o_byte_out_oe) |-> i_scan && !i_enable_n)
      else $error("bus driven without cause");
   step_fall_a: assert property ($fell(o_cascade_n) |-> !i_scan && !i_enable_n)
      else $error("state step off a scan fall");
endmodule
bind drc_counter drc_mon i_drc_mon (
   .i_mclk(i_mclk),
   .i_rst_n(i_rst_n),
   .i_scan(i_scan),
   .i_scan_reset_load_n(i_scan_reset_load_n),
   .i_enable_n(i_enable_n),
   .o_byte_out_oe(o_byte_out_oe),
   .o_cascade_n(o_cascade_n)
);
`default_nettype wire

// ==== drc_host.sv ====
// Host model: restarts the capture, then scans four bytes off the bus.
// Assumes the bench pulses i_go for one cycle; i_skip skips the restart.
`default_nettype none
module drc_host (
   // Clock and commands
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic i_skip,
   // Device bus
   input wire logic i_oe,
   input wire logic [7:0] i_data,
   // Strobes to the device
   output logic o_scan,
   output logic o_load_n,
   // Results
   output logic [31:0] o_word,
   output logic o_seen,
   output logic o_done
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PH = 100; // 500 ns phases
   logic [7:0] bus;
   logic [7:0] last = 8'h00;
   // Released bus flips every cycle so stale data never matches
   assign bus = i_oe ? i_data : ~last;
   always @(posedge i_mclk) last <= bus;
   // Strobes change on falling edges only
   initial begin
      o_scan = 1'b0;
      o_load_n = 1'b1;
      o_word = 32'h0;
      o_seen = 1'b0;
      o_done = 1'b0;
      forever begin
         @(posedge i_mclk);
         if (i_go === 1'b1) begin
            o_done = 1'b0;
            o_seen = 1'b0;
            @(negedge i_mclk);
            if (i_skip !== 1'b1) begin
               o_load_n = 1'b0;
               repeat (2 * PH) @(negedge i_mclk);
               o_load_n = 1'b1;
               repeat (PH) @(negedge i_mclk);
            end
            for (int k = 0; k < 4; k++) begin
               o_scan = 1'b1;
               repeat (PH) @(negedge i_mclk);
               o_word[8*k +: 8] = bus;
               o_seen = o_seen | i_oe;
               o_scan = 1'b0;
               repeat (PH) @(negedge i_mclk);
            end
            o_done = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== drc_counter_tb_top.sv ====
// Bench: counts, clears and reads the dual counter through the host model.
// Assumes the host model owns the scan and restart strobes.
`default_nettype none
module drc_counter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] cnt = 3'h0; // A, alternate A, B count pins
   logic i_cnt_reset_n = 1'b1;
   logic i_enable_n = 1'b0;
   logic go = 1'b0;
   logic skip = 1'b0;
   wire scan, load_n, oe, casc, seen, done;
   wire [7:0] data;
   wire [31:0] word;
   int err_total = 0;
   int total_checks = 0;
   drc_counter i_drc_counter (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_count_a(cnt[0]), .i_alt_count_a(cnt[1]), .i_count_b(cnt[2]),
      .i_cnt_reset_n(i_cnt_reset_n), .i_scan(scan), .i_scan_reset_load_n(load_n),
      .i_enable_n(i_enable_n), .o_byte_out_lines(data), .o_byte_out_oe(oe),
      .o_cascade_n(casc));
   drc_host i_drc_host (.i_mclk(i_mclk), .i_go(go), .i_skip(skip), .i_oe(oe),
      .i_data(data), .o_scan(scan), .o_load_n(load_n), .o_word(word),
      .o_seen(seen), .o_done(done));
   initial forever #2.5 i_mclk = ~i_mclk;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Pulses of 10 cycles a phase on one count pin
   task automatic pulse(input int w, input int n);
      repeat (n) begin
         @(negedge i_mclk);
         cnt[w] = 1'b1;
         repeat (10) @(negedge i_mclk);
         cnt[w] = 1'b0;
         repeat (10) @(negedge i_mclk);
      end
   endtask
   // Ripple wait, then one host read under a bounded wait
   task automatic read(input logic s);
      int i;
      repeat (400) @(negedge i_mclk);
      skip = s;
      go = 1'b1;
      @(negedge i_mclk);
      go = 1'b0;
      for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge i_mclk);
      if (done !== 1'b1) begin
         err_total++;
         wrap_up();
      end
   endtask
   task automatic s_count();
      pulse(0, 3);
      pulse(2, 2);
      cnt[0] = 1'b1; // Held A inhibits the alternate pulses
      pulse(1, 2);
      cnt[0] = 1'b0;
      read(1'b0);
      check(word, 32'h0002_0004);
      check(seen, 1'b1);
      check(casc, 1'b0);
   endtask
   task automatic s_hold();
      read(1'b1);
      check(seen, 1'b0);
      check(casc, 1'b0);
   endtask
   task automatic s_clear();
      i_cnt_reset_n = 1'b0;
      repeat (200) @(negedge i_mclk);
      i_cnt_reset_n = 1'b1;
      repeat (60) @(negedge i_mclk);
      pulse(0, 1);
      read(1'b0);
      check(word, 32'h0000_0001);
   endtask
   // Enable stands in for the handoff of an upstream device in a chain
   task automatic s_enable();
      i_enable_n = 1'b1;
      read(1'b0);
      check(seen, 1'b0);
      check(casc, 1'b1);
      // Upstream reached its last state: bytes follow with no new restart
      i_enable_n = 1'b0;
      read(1'b1);
      check(word, 32'h0000_0001);
      check(seen, 1'b1);
      check(casc, 1'b0);
   endtask
   initial begin
      repeat (10) @(negedge i_mclk);
      i_rst_n = 1'b1;
      repeat (20) @(negedge i_mclk);
      s_count();
      s_hold();
      s_clear();
      s_enable();
      wrap_up();
   end
endmodule
`default_nettype wire
